// *** logic/hps_pkg.sv ***
// package of constants and types for the handset power sequencer
package hps_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int DEBOUNCE_MS = 32;
  localparam int REG_DLY_STD_US = 125;
  localparam int REG_DLY_OPT_MS = 10;
  localparam int RST_DLY_MS = 20;
  localparam int HOLD_TMO_MS = 500;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int REG_DLY_STD_CYC = REG_DLY_STD_US * (CLK_HZ / 1000000);
  localparam int REG_DLY_OPT_CYC = REG_DLY_OPT_MS * (CLK_HZ / 1000);
  localparam int RST_DLY_CYC = RST_DLY_MS * (CLK_HZ / 1000);
  localparam int HOLD_TMO_CYC = HOLD_TMO_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 24;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_FIRST_UP = 3'b001,
    ST_SECOND_UP = 3'b010,
    ST_RST_WAIT = 3'b011,
    ST_ON = 3'b100,
    ST_DN_RST = 3'b101,
    ST_DN_SECOND = 3'b110
  } hps_state_e;

  // output-good flags from the two regulator comparators
  typedef struct packed {
    logic first_good;
    logic second_good;
  } hps_good_s;

  // regulator enables toward the analog section
  typedef struct packed {
    logic first_en;
    logic second_en;
  } hps_en_s;
endpackage : hps_pkg

// *** logic/hps_sequencer.sv ***
// power-up and power-down sequencer with debounce and hold supervision
`timescale 1ns/100ps
module hps_sequencer #(
  parameter int DEBOUNCE_CYCLES = hps_pkg::DEBOUNCE_CYC,
  parameter int REG_DLY_STD_CYCLES = hps_pkg::REG_DLY_STD_CYC,
  parameter int REG_DLY_OPT_CYCLES = hps_pkg::REG_DLY_OPT_CYC,
  parameter int RST_DLY_CYCLES = hps_pkg::RST_DLY_CYC,
  parameter int HOLD_TMO_CYCLES = hps_pkg::HOLD_TMO_CYC
) (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic KEYPAD_WAKE_I,
  input wire logic CHARGER_DETECT_N_I,
  input wire logic POWER_HOLD_I,
  input wire logic REG_DLY_OPTION_I,
  input wire hps_pkg::hps_good_s GOOD_I,
  output logic WAKE_IRQ_N_O,
  output logic PROC_RESET_N_O,
  output hps_pkg::hps_en_s REG_EN_O,
  output logic CHARGER_SEEN_O
);
  import hps_pkg::*;

  hps_state_e state_r, state_nxt;
  logic [CNT_W-1:0] kdb_r, cdb_r, tmr_r;
  logic key_ok, chg_ok, key_ok_d_r, chg_ok_d_r;
  logic irq_n_r, rst_n_r, first_en_r, second_en_r, chg_seen_r;
  logic hold_d_r, hold_tmr_live_r;

  function automatic logic [CNT_W-1:0] to_cnt(input int v);
    to_cnt = v[CNT_W-1:0];
  endfunction : to_cnt

  // debounce limits and delay thresholds from one timebase
  wire [CNT_W-1:0] db_lim = to_cnt(DEBOUNCE_CYCLES);
  wire [CNT_W-1:0] reg_dly = REG_DLY_OPTION_I ? to_cnt(REG_DLY_OPT_CYCLES)
                                              : to_cnt(REG_DLY_STD_CYCLES);
  wire [CNT_W-1:0] rst_dly = to_cnt(RST_DLY_CYCLES);
  wire [CNT_W-1:0] hold_lim = to_cnt(HOLD_TMO_CYCLES);
  wire chg_low = ~CHARGER_DETECT_N_I;
  wire key_rise = key_ok & ~key_ok_d_r;
  wire chg_rise = chg_ok & ~chg_ok_d_r;
  wire hold_fall = hold_d_r & ~POWER_HOLD_I;
  wire tmr_hit_reg = (tmr_r >= reg_dly - 1'b1);
  wire tmr_hit_rst = (tmr_r >= rst_dly - 1'b1);
  wire hold_expired = hold_tmr_live_r & (tmr_r >= hold_lim - 1'b1);
  wire reg_fail = (first_en_r & ~GOOD_I.first_good)
                | (second_en_r & ~GOOD_I.second_good);
  // power-down other than on a regulator fault or hold timeout allowed only with charger gone and hold low
  wire may_shut = ~chg_low & ~POWER_HOLD_I;
  wire in_on = (state_r == ST_ON);

  // debounce counters: saturate once the input has stayed active long enough
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      kdb_r <= '0;
      cdb_r <= '0;
    end else begin
      kdb_r <= !KEYPAD_WAKE_I ? '0 : (kdb_r < db_lim ? kdb_r + 1'b1 : kdb_r);
      cdb_r <= !chg_low ? '0 : (cdb_r < db_lim ? cdb_r + 1'b1 : cdb_r);
    end
  end

  assign key_ok = (kdb_r >= db_lim);
  assign chg_ok = (cdb_r >= db_lim);

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      key_ok_d_r <= 1'b0;
      chg_ok_d_r <= 1'b0;
      hold_d_r <= 1'b0;
    end else begin
      key_ok_d_r <= key_ok;
      chg_ok_d_r <= chg_ok;
      hold_d_r <= POWER_HOLD_I;
    end
  end

  // sequence state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: begin
        if (key_rise || chg_rise)
          state_nxt = ST_FIRST_UP;
      end
      ST_FIRST_UP: begin
        if (GOOD_I.first_good && tmr_hit_reg)
          state_nxt = ST_SECOND_UP;
      end
      ST_SECOND_UP: begin
        if (GOOD_I.second_good)
          state_nxt = ST_RST_WAIT;
      end
      ST_RST_WAIT: begin
        if (tmr_hit_rst)
          state_nxt = ST_ON;
      end
      ST_ON: begin
        // regulator fault, hold drop, or timeout without charger
        if (reg_fail)
          state_nxt = ST_DN_RST;
        else if (hold_expired && !chg_low)
          state_nxt = ST_DN_RST;
        else if (may_shut && (hold_fall || !hold_tmr_live_r))
          state_nxt = ST_DN_RST;
      end
      ST_DN_RST: begin
        if (tmr_hit_rst)
          state_nxt = ST_DN_SECOND;
      end
      ST_DN_SECOND: begin
        if (!GOOD_I.second_good && tmr_hit_reg)
          state_nxt = ST_OFF;
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  // shared delay timer restarts on each state change; in ST_FIRST_UP and
  // ST_DN_SECOND it counts only once the comparator condition holds
  wire tmr_hold0 = (state_r == ST_FIRST_UP && !GOOD_I.first_good)
                 || (state_r == ST_DN_SECOND && GOOD_I.second_good);
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I)
      tmr_r <= '0;
    else if (state_nxt != state_r || tmr_hold0)
      tmr_r <= '0;
    else if (tmr_r != {CNT_W{1'b1}})
      tmr_r <= tmr_r + 1'b1;
  end

  // hold supervision live from reset release until hold first seen high
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I)
      hold_tmr_live_r <= 1'b0;
    else if (state_r == ST_RST_WAIT && state_nxt == ST_ON)
      hold_tmr_live_r <= 1'b1;
    else if (!in_on || POWER_HOLD_I)
      hold_tmr_live_r <= 1'b0;
  end

  // output registers; interrupt set wins over clear in the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      irq_n_r <= 1'b1;
      rst_n_r <= 1'b0;
      first_en_r <= 1'b0;
      second_en_r <= 1'b0;
      chg_seen_r <= 1'b0;
    end else begin
      if (key_rise)
        irq_n_r <= 1'b0;
      else if (in_on && (POWER_HOLD_I || hold_expired))
        irq_n_r <= 1'b1;
      else if (state_r == ST_OFF)
        irq_n_r <= 1'b1;
      rst_n_r <= (state_nxt == ST_ON);
      first_en_r <= (state_nxt != ST_OFF);
      second_en_r <= (state_nxt == ST_SECOND_UP) || (state_nxt == ST_RST_WAIT)
                  || (state_nxt == ST_ON) || (state_nxt == ST_DN_RST);
      if (!in_on)
        chg_seen_r <= 1'b0;
      else if (chg_rise)
        chg_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  // good flags stay inside; only enables, reset, interrupt and charger-seen flag leave
  assign WAKE_IRQ_N_O = irq_n_r;
  assign PROC_RESET_N_O = rst_n_r;
  assign REG_EN_O = '{first_en: first_en_r, second_en: second_en_r};
  assign CHARGER_SEEN_O = chg_seen_r;

  property p_key_wakes;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (state_r == ST_OFF && key_rise) |=> first_en_r;
  endproperty
  a_key_wakes: assert property (p_key_wakes)
    else $error("keypad wake did not enable first regulator");

  property p_irq_on_key;
    @(posedge CLOCK_I) disable iff (SRST_I)
    key_rise |=> !WAKE_IRQ_N_O;
  endproperty
  a_irq_on_key: assert property (p_irq_on_key)
    else $error("wake interrupt not asserted after debounce");

  property p_second_after_first;
    @(posedge CLOCK_I) disable iff (SRST_I)
    $rose(second_en_r) |-> first_en_r && GOOD_I.first_good;
  endproperty
  a_second_after_first: assert property (p_second_after_first)
    else $error("second regulator enabled before first good");

  property p_reset_needs_both;
    @(posedge CLOCK_I) disable iff (SRST_I)
    $rose(rst_n_r) |-> first_en_r && second_en_r;
  endproperty
  a_reset_needs_both: assert property (p_reset_needs_both)
    else $error("reset released without both regulators");

  property p_fault_resets;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (in_on && reg_fail) |=> !PROC_RESET_N_O;
  endproperty
  a_fault_resets: assert property (p_fault_resets)
    else $error("regulator fault did not assert reset");

  property p_charger_keeps_on;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (in_on && chg_low && !reg_fail) |=> PROC_RESET_N_O && second_en_r;
  endproperty
  a_charger_keeps_on: assert property (p_charger_keeps_on)
    else $error("shutdown while charger present");

  property p_second_off_late;
    @(posedge CLOCK_I) disable iff (SRST_I)
    $fell(rst_n_r) |-> second_en_r [*2];
  endproperty
  a_second_off_late: assert property (p_second_off_late)
    else $error("second regulator dropped with reset");

  property p_first_off_last;
    @(posedge CLOCK_I) disable iff (SRST_I)
    $fell(first_en_r) |-> !second_en_r && !rst_n_r;
  endproperty
  a_first_off_last: assert property (p_first_off_last)
    else $error("first regulator off before second");

  property p_hold_timeout;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (in_on && hold_expired && !chg_low) |=> !PROC_RESET_N_O && WAKE_IRQ_N_O;
  endproperty
  a_hold_timeout: assert property (p_hold_timeout)
    else $error("hold timeout not handled");

  // hold handshake, keypad and wake interrupt cases, charger cases and the delay phases of the sequence
  property p_hold_clears_irq;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (in_on && POWER_HOLD_I && !key_rise) |=> WAKE_IRQ_N_O;
  endproperty
  a_hold_clears_irq: assert property (p_hold_clears_irq)
    else $error("hold high did not clear wake interrupt");

  property p_hold_fall_resets;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (in_on && may_shut && hold_fall) |=> !PROC_RESET_N_O;
  endproperty
  a_hold_fall_resets: assert property (p_hold_fall_resets)
    else $error("falling hold did not assert reset");

  property p_key_keeps_on;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (in_on && key_rise && POWER_HOLD_I && !reg_fail && !hold_expired)
      |=> PROC_RESET_N_O && !WAKE_IRQ_N_O;
  endproperty
  a_key_keeps_on: assert property (p_key_keeps_on)
    else $error("later keypad press changed power state");

  property p_charger_recorded;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (in_on && chg_rise && !reg_fail)
      |=> CHARGER_SEEN_O && PROC_RESET_N_O && $stable(REG_EN_O);
  endproperty
  a_charger_recorded: assert property (p_charger_recorded)
    else $error("charger while on not recorded or disturbed outputs");

  property p_charger_wakes;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (state_r == ST_OFF && chg_rise) |=> REG_EN_O.first_en;
  endproperty
  a_charger_wakes: assert property (p_charger_wakes)
    else $error("charger did not enable first regulator");

  property p_quiet_irq;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (!in_on && !key_rise && WAKE_IRQ_N_O) |=> WAKE_IRQ_N_O;
  endproperty
  a_quiet_irq: assert property (p_quiet_irq)
    else $error("wake interrupt asserted without keypad event");

  property p_charger_blocks_tmo;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (in_on && chg_low && hold_expired && !reg_fail) |=> PROC_RESET_N_O;
  endproperty
  a_charger_blocks_tmo: assert property (p_charger_blocks_tmo)
    else $error("hold timeout acted while charger present");

  property p_hold_timer_start;
    @(posedge CLOCK_I) disable iff (SRST_I)
    $rose(PROC_RESET_N_O) |-> hold_tmr_live_r && (tmr_r == '0);
  endproperty
  a_hold_timer_start: assert property (p_hold_timer_start)
    else $error("hold timer not started at reset release");

  property p_second_held_in_dn;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (state_r == ST_DN_RST && !tmr_hit_rst) |=> REG_EN_O.second_en;
  endproperty
  a_second_held_in_dn: assert property (p_second_held_in_dn)
    else $error("second regulator disabled before reset delay");

  property p_second_waits_dly;
    @(posedge CLOCK_I) disable iff (SRST_I)
    (state_r == ST_FIRST_UP && !tmr_hit_reg) |=> !REG_EN_O.second_en;
  endproperty
  a_second_waits_dly: assert property (p_second_waits_dly)
    else $error("second regulator enabled before regulator delay");

  c_key_up: cover property (@(posedge CLOCK_I) $rose(rst_n_r) && !irq_n_r);
  c_chg_up: cover property (@(posedge CLOCK_I) $rose(rst_n_r) && irq_n_r);
  c_down: cover property (@(posedge CLOCK_I) $fell(first_en_r));
  c_chg_seen: cover property (@(posedge CLOCK_I) $rose(chg_seen_r));
  c_tmo: cover property (@(posedge CLOCK_I) in_on && hold_expired);
endmodule : hps_sequencer

// *** sim/hps_host_model.sv ***
// host processor and regulator comparator model for the sequencer bench
`timescale 1ns/100ps
module hps_host_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire hps_pkg::hps_en_s en_i,
  input wire logic keep_on_i,
  input wire logic fault_i,
  output hps_pkg::hps_good_s good_o,
  output logic hold_o
);
  import hps_pkg::*;
  int up_cnt = 0;
  // comparators follow the enables one cycle late; fault pulls the first low
  // host raises hold 11 cycles after reset release, drops it when in reset
  always @(posedge clk_i) begin
    good_o.first_good <= en_i.first_en & ~fault_i;
    good_o.second_good <= en_i.second_en;
    up_cnt <= rst_n_i ? up_cnt + 1 : 0;
    hold_o <= keep_on_i & rst_n_i & (up_cnt >= 10);
  end
endmodule : hps_host_model

// *** sim/tb.sv ***
// self-checking bench for the handset power sequencer
`timescale 1ns/100ps
module tb;
  import hps_pkg::*;
  // short counts keep the run brief; the debounce, delay and timeout windows below derive from them
  localparam int DB = 20;
  localparam int RS = 5;
  localparam int RO = 20;
  localparam int RD = 20;
  localparam int HT = 40;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic key = 1'b0;
  logic chg_n = 1'b1;
  logic opt = 1'b0;
  logic keep_on = 1'b0;
  logic fault = 1'b0;
  logic hold, irq_n, rst_n, seen;
  hps_good_s good;
  hps_en_s en;
  int error_cnt = 0;
  int comparisons = 0;
  // 0 irq, 1 reset, 2 first enable, 3 second enable, 4 charger seen
  wire [4:0] outs = {seen, en.second_en, en.first_en, rst_n, irq_n};

  always #25 clk = ~clk;

  hps_sequencer #(.DEBOUNCE_CYCLES(DB), .REG_DLY_STD_CYCLES(RS),
    .REG_DLY_OPT_CYCLES(RO), .RST_DLY_CYCLES(RD), .HOLD_TMO_CYCLES(HT)
  ) i_hps_sequencer (.CLOCK_I(clk), .SRST_I(srst), .KEYPAD_WAKE_I(key),
    .CHARGER_DETECT_N_I(chg_n), .POWER_HOLD_I(hold),
    .REG_DLY_OPTION_I(opt), .GOOD_I(good), .WAKE_IRQ_N_O(irq_n),
    .PROC_RESET_N_O(rst_n), .REG_EN_O(en), .CHARGER_SEEN_O(seen));

  hps_host_model i_hps_host_model (.clk_i(clk), .rst_n_i(rst_n),
    .en_i(en), .keep_on_i(keep_on), .fault_i(fault), .good_o(good),
    .hold_o(hold));

  task automatic results();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // inclusive window compare; an unknown never lands inside it
  task automatic check(string name, logic [31:0] v, int lo, int hi);
    comparisons++;
    if ((v >= lo && v <= hi) !== 1'b1) begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, v);
    end
  endtask : check

  // bounded wait on one output; n counts rising edges until it matches
  task automatic wait_out(int idx, logic v, int max, output int n);
    for (n = 1; n <= max; n++) begin
      @(posedge clk);
      #1;
      if (outs[idx] === v) return;
    end
    error_cnt++;
    $display("ERROR output %0d expected %b seen timeout", idx, v);
    results();
  endtask : wait_out

  task automatic power_up(logic by_key, int reg_d);
    int n;
    @(negedge clk);
    key = by_key;
    chg_n = by_key;
    wait_out(2, 1'b1, DB + 8, n);
    check("first enable", n, DB, DB + 3);
    check("wake irq", irq_n, !by_key, !by_key);
    wait_out(3, 1'b1, reg_d + 8, n);
    check("second enable", n, reg_d, reg_d + 5);
    wait_out(1, 1'b1, RD + 8, n);
    check("reset release", n, RD, RD + 4);
    check("irq at release", irq_n, !by_key, !by_key);
    @(negedge clk);
    key = 1'b0;
  endtask : power_up

  task automatic power_down(int reg_d, int lo, int hi);
    int n;
    wait_out(1, 1'b0, hi + 2, n);
    check("reset fall", n, lo, hi);
    wait_out(3, 1'b0, RD + 8, n);
    check("second disable", n, RD - 1, RD + 3);
    wait_out(2, 1'b0, reg_d + 8, n);
    check("first disable", n, reg_d, reg_d + 5);
  endtask : power_down

  task automatic sc_key_cycle();
    int n;
    keep_on = 1'b1;
    power_up(1'b1, RS);
    wait_out(0, 1'b1, 16, n);
    check("irq clear on hold", n, 11, 14);
    repeat (HT + 10) @(negedge clk);
    check("on after hold", {rst_n, en}, 7, 7);
    key = 1'b1;
    wait_out(0, 1'b0, DB + 8, n);
    check("second press", {rst_n, en}, 7, 7);
    @(negedge clk);
    key = 1'b0;
    chg_n = 1'b0;
    wait_out(4, 1'b1, DB + 8, n);
    check("charger while on", {irq_n, rst_n, en}, 15, 15);
    @(negedge clk);
    chg_n = 1'b1;
    keep_on = 1'b0;
    power_down(RS, 1, 4);
  endtask : sc_key_cycle

  task automatic sc_timeout();
    @(negedge clk);
    key = 1'b1;
    repeat (DB - 4) @(negedge clk);
    key = 1'b0;
    repeat (DB) @(negedge clk);
    check("short press", {irq_n, rst_n, en}, 8, 8);
    power_up(1'b1, RS);
    power_down(RS, HT, HT + 4);
    check("irq after timeout", irq_n, 1, 1);
  endtask : sc_timeout

  // optional long regulator delay, hold never raised while charging
  task automatic sc_charger();
    @(negedge clk);
    opt = 1'b1;
    power_up(1'b0, RO);
    repeat (HT + 10) @(negedge clk);
    check("charger holds", {irq_n, rst_n, en}, 15, 15);
    chg_n = 1'b1;
    power_down(RO, 1, 4);
    @(negedge clk);
    opt = 1'b0;
  endtask : sc_charger

  task automatic sc_fault();
    int n;
    keep_on = 1'b1;
    power_up(1'b1, RS);
    fault = 1'b1;
    wait_out(1, 1'b0, 6, n);
    check("reset on fault", n, 1, 4);
    wait_out(2, 1'b0, RD + RS + 12, n);
    check("first off after fault", n, RD + RS, RD + RS + 4);
    @(negedge clk);
    fault = 1'b0;
    keep_on = 1'b0;
  endtask : sc_fault

  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    sc_key_cycle();
    sc_timeout();
    sc_charger();
    sc_fault();
    results();
  end
endmodule : tb
